//--- hdl/chd_pkg.sv
// Constants shared by the cyclic data handshake block.
// Assumes a single 100 MHz clock and a classic Wishbone register port.
package chd_pkg;
   // ************************************************************
   // Widths
   // ************************************************************
   localparam int CNT_W    = 8;
   localparam int SERIAL_W = 24;
   localparam int LEN_W    = 16;
   localparam int CODE_W   = 3;
   localparam int WB_AW    = 4;

   // ************************************************************
   // Payload sizes and their configuration codes
   // ************************************************************
   localparam logic [LEN_W-1:0]  SZ_8     = 16'h0008;
   localparam logic [LEN_W-1:0]  SZ_16    = 16'h0010;
   localparam logic [LEN_W-1:0]  SZ_32    = 16'h0020;
   localparam logic [LEN_W-1:0]  SZ_64    = 16'h0040;
   localparam logic [LEN_W-1:0]  SZ_128   = 16'h0080;
   localparam logic [LEN_W-1:0]  SZ_240   = 16'h00F0;
   localparam logic [CODE_W-1:0] CODE_8   = 3'h0;
   localparam logic [CODE_W-1:0] CODE_16  = 3'h1;
   localparam logic [CODE_W-1:0] CODE_32  = 3'h2;
   localparam logic [CODE_W-1:0] CODE_64  = 3'h3;
   localparam logic [CODE_W-1:0] CODE_128 = 3'h4;
   localparam logic [CODE_W-1:0] RES_CODE_RST = CODE_16;
   localparam logic [CODE_W-1:0] PRM_CODE_RST = CODE_16;

   // ************************************************************
   // Control and confirmation byte bits
   // ************************************************************
   localparam int ACT_BIT  = 0;
   localparam int MODE_BIT = 1;
   localparam int OVF_BIT  = 6;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [WB_AW-1:0] ADR_CFG    = 4'h0;
   localparam logic [WB_AW-1:0] ADR_RESULT = 4'h4;
   localparam logic [WB_AW-1:0] ADR_LINK   = 4'h8;
   localparam int CFG_RES_LSB  = 0;
   localparam int CFG_PRM_LSB  = 4;
   localparam int RES_CNT_LSB  = 24;
   localparam int LNK_ICNT_LSB = 8;
   localparam int LNK_OCNF_LSB = 16;
   localparam int LNK_OACK_LSB = 24;

   typedef enum logic [0:0] {PRM_IDLE, PRM_PEND} chd_prm_type;
endpackage

//--- hdl/chd_lenclamp.sv
// Decodes a payload size code and clamps a length to that size.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module chd_lenclamp (
   // Configuration
   input  wire logic [chd_pkg::CODE_W-1:0] code,
   // Length
   input  wire logic [chd_pkg::LEN_W-1:0]  len_in,
   output logic      [chd_pkg::LEN_W-1:0]  len_out
);
   logic [chd_pkg::LEN_W-1:0] size;

   always_comb begin
      case (code)
         chd_pkg::CODE_8:   size = chd_pkg::SZ_8;
         chd_pkg::CODE_16:  size = chd_pkg::SZ_16;
         chd_pkg::CODE_32:  size = chd_pkg::SZ_32;
         chd_pkg::CODE_64:  size = chd_pkg::SZ_64;
         chd_pkg::CODE_128: size = chd_pkg::SZ_128;
         // Unused codes fall back to the largest area
         default:           size = chd_pkg::SZ_240;
      endcase
      len_out = (len_in > size) ? size : len_in;
   end
endmodule
`default_nettype wire

//--- hdl/chd_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
// Same clock and reset as its user.
`timescale 1ns/10ps
`default_nettype none
module chd_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Fill side
   input  wire logic         s_valid,
   output logic             s_ready,
   input  wire logic [W-1:0] s_data,
   // Drain side
   output logic             m_valid,
   input  wire logic         m_ready,
   output logic      [W-1:0] m_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [CW-1:0]           cnt;
      logic                    rdy;
   } chd_fifo_type;

   chd_fifo_type s_r;
   chd_fifo_type s_nxt;
   logic         push;
   logic         pop;

   assign s_ready = s_r.rdy;
   assign m_valid = (s_r.cnt != '0);
   assign m_data  = s_r.mem[s_r.rp];

   always_comb begin
      s_nxt = s_r;
      push  = s_valid && s_r.rdy;
      pop   = m_valid && m_ready;
      if (push) begin
         s_nxt.mem[s_r.wp] = s_data;
         s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
      end
      if (push && !pop) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (pop && !push) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
      // Registered so that the fill side sees a flop
      s_nxt.rdy = (s_nxt.cnt != CW'(DEPTH));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r     <= '0;
         s_r.rdy <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

//--- hdl/chd_top.sv
// Device end of the cyclic process-data handshake: result publishing
// toward the controller and new-data detection from the controller.
// Assumes the controller image arrives as same-clock logic signals.
//
// Operation
// - Two modes: simple and acknowledged
// - Sender bumps counter on every new transfer
// - Device reflects input activation and mode bits
// - Input counter increments per result published while the input channel is active
// - Simple mode ignores controller acknowledge counter
// - Device reflects output activation and mode bits
// - Changed output counter means new data
// - Result serial increments per result, wraps
// - Result length holds valid payload byte count
// - Result area size selectable, default sixteen
// - Parameter area size selectable, length precedes
// - Mode bit set selects acknowledged mode
// - Receiver echoes last counter as acknowledge
// - Sender waits for matching acknowledge counter
// - Pending results queue while awaiting acknowledge
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module chd_top #(
   parameter int BUF_DEPTH = 2
) (
   // Clock and reset
   input  wire logic                          MCLK,
   input  wire logic                          RESETN,
   // Wishbone slave
   input  wire logic                          WB_CYC_I,
   input  wire logic                          WB_STB_I,
   input  wire logic                          WB_WE_I,
   input  wire logic [chd_pkg::WB_AW-1:0]     WB_ADR_I,
   input  wire logic [3:0]                    WB_SEL_I,
   input  wire logic [31:0]                   WB_DAT_I,
   output logic      [31:0]                   WB_DAT_O,
   output logic                               WB_ACK_O,
   // Results from the evaluation logic
   input  wire logic                          RES_VALID,
   output logic                               RES_READY,
   input  wire logic                          RES_PASS,
   input  wire logic                          RES_FAIL,
   input  wire logic [chd_pkg::LEN_W-1:0]     RES_LEN,
   // Published result frame
   output logic                               RES_NEW,
   output logic      [chd_pkg::SERIAL_W-1:0]  RESULT_SERIAL,
   output logic                               RES_PASS_OUT,
   output logic                               RES_FAIL_OUT,
   output logic      [chd_pkg::LEN_W-1:0]     RES_LEN_OUT,
   // Input channel, controller side
   input  wire logic [chd_pkg::CNT_W-1:0]     IN_SYNC_CONTROL,
   input  wire logic [chd_pkg::CNT_W-1:0]     IN_ACKNOWLEDGE_COUNTER,
   output logic      [chd_pkg::CNT_W-1:0]     IN_SYNC_CONFIRM_BYTE,
   output logic      [chd_pkg::CNT_W-1:0]     IN_TRANSFER_COUNTER,
   // Output channel, controller side
   input  wire logic [chd_pkg::CNT_W-1:0]     OUT_SYNC_CONTROL,
   input  wire logic [chd_pkg::CNT_W-1:0]     OUT_TRANSFER_COUNTER,
   input  wire logic [chd_pkg::LEN_W-1:0]     PRM_LEN,
   output logic      [chd_pkg::CNT_W-1:0]     OUT_SYNC_CONFIRM_BYTE,
   output logic      [chd_pkg::CNT_W-1:0]     OUT_ACKNOWLEDGE_COUNTER,
   // New parameter data toward the device logic
   output logic                               PRM_VALID,
   input  wire logic                          PRM_READY,
   output logic      [chd_pkg::LEN_W-1:0]     PRM_LEN_OUT
);
   localparam int BW = chd_pkg::LEN_W + 2;

   typedef struct packed {
      logic [chd_pkg::CODE_W-1:0]   cfg_res;
      logic [chd_pkg::CODE_W-1:0]   cfg_prm;
      logic                         wb_ack;
      logic [31:0]                  wb_dat;
      logic                         res_new;
      logic [chd_pkg::SERIAL_W-1:0] serial;
      logic                         pass;
      logic                         fail;
      logic [chd_pkg::LEN_W-1:0]    res_len;
      logic                         ovf;
      logic [chd_pkg::CNT_W-1:0]    in_conf;
      logic [chd_pkg::CNT_W-1:0]    in_cnt;
      logic [chd_pkg::CNT_W-1:0]    out_conf;
      logic [chd_pkg::CNT_W-1:0]    out_ack;
      logic [chd_pkg::CNT_W-1:0]    out_seen;
      logic [chd_pkg::CNT_W-1:0]    prm_cnt;
      chd_pkg::chd_prm_type         prm_st;
      logic                         prm_valid;
      logic [chd_pkg::LEN_W-1:0]    prm_len;
   } chd_state_type;

   chd_state_type             s_r;
   chd_state_type             s_nxt;
   logic                      buf_valid;
   logic                      buf_ready;
   logic [BW-1:0]             buf_data;
   logic                      fifo_ready;
   logic [chd_pkg::LEN_W-1:0] res_len_clamp;
   logic [chd_pkg::LEN_W-1:0] prm_len_clamp;
   logic                      in_en;
   logic                      in_ack_mode;
   logic                      out_en;
   logic                      wait_ack;
   logic                      wb_req;
   logic [chd_pkg::WB_AW-1:0] wb_off;
   logic [31:0]               rd_data;
   logic                      wb_wr;
   logic                      publish;
   logic                      prm_new;

   // ************************************************************
   // Result queue
   // ************************************************************
   // Holds results while the controller has not acknowledged yet
   chd_fifo #(
      .W     (BW),
      .DEPTH (BUF_DEPTH)
   ) u_res_buf (
      .clk     (MCLK),
      .rst_n   (RESETN),
      .s_valid (RES_VALID),
      .s_ready (fifo_ready),
      .s_data  ({RES_PASS, RES_FAIL, RES_LEN}),
      .m_valid (buf_valid),
      .m_ready (buf_ready),
      .m_data  (buf_data)
   );

   chd_lenclamp u_res_len (
      .code    (s_r.cfg_res),
      .len_in  (buf_data[chd_pkg::LEN_W-1:0]),
      .len_out (res_len_clamp)
   );

   chd_lenclamp u_prm_len (
      .code    (s_r.cfg_prm),
      .len_in  (PRM_LEN),
      .len_out (prm_len_clamp)
   );

   // ************************************************************
   // Channel decode
   // ************************************************************
   assign in_en       = IN_SYNC_CONTROL[chd_pkg::ACT_BIT];
   assign in_ack_mode = in_en && IN_SYNC_CONTROL[chd_pkg::MODE_BIT];
   assign out_en      = OUT_SYNC_CONTROL[chd_pkg::ACT_BIT];
   // Simple mode never looks at the acknowledge counter
   assign wait_ack    = in_ack_mode && (IN_ACKNOWLEDGE_COUNTER != s_r.in_cnt);
   assign buf_ready   = !wait_ack;
   assign wb_req      = WB_CYC_I && WB_STB_I;
   assign wb_off      = {WB_ADR_I[chd_pkg::WB_AW-1:2], 2'h0};
   // One result leaves the queue per cycle; in acknowledged mode it
   // waits until the controller has echoed the current counter
   assign publish     = buf_valid && buf_ready;
   // Only looked at while idle; a change made during a pending transfer is taken after it
   assign prm_new     = out_en && (OUT_TRANSFER_COUNTER != s_r.out_seen);

   // ************************************************************
   // Bus decode
   // ************************************************************
   // A write lands on the edge that samples ack high, where the master
   // completes the cycle, so an abandoned request writes nothing
   assign wb_wr       = wb_req && s_r.wb_ack && WB_WE_I && WB_SEL_I[0];

   // ************************************************************
   // Register read data
   // ************************************************************
   always_comb begin
      rd_data = 32'h0;
      // Unmapped offsets read as zero and ignore writes
      case (wb_off)
         chd_pkg::ADR_CFG: begin
            rd_data[chd_pkg::CFG_RES_LSB +: chd_pkg::CODE_W] = s_r.cfg_res;
            rd_data[chd_pkg::CFG_PRM_LSB +: chd_pkg::CODE_W] = s_r.cfg_prm;
         end
         chd_pkg::ADR_RESULT: begin
            rd_data[chd_pkg::SERIAL_W-1:0]                  = s_r.serial;
            rd_data[chd_pkg::RES_CNT_LSB +: chd_pkg::CNT_W] = s_r.in_cnt;
         end
         chd_pkg::ADR_LINK: begin
            rd_data[chd_pkg::CNT_W-1:0]                      = s_r.in_conf;
            rd_data[chd_pkg::LNK_ICNT_LSB +: chd_pkg::CNT_W] = s_r.in_cnt;
            rd_data[chd_pkg::LNK_OCNF_LSB +: chd_pkg::CNT_W] = s_r.out_conf;
            rd_data[chd_pkg::LNK_OACK_LSB +: chd_pkg::CNT_W] = s_r.out_ack;
         end
         default: begin
            rd_data = 32'h0;
         end
      endcase
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      s_nxt = s_r;

      // Bus: one wait state, ack dropped right after it was given
      s_nxt.wb_ack = wb_req && !s_r.wb_ack;
      s_nxt.wb_dat = rd_data;
      if (wb_wr && (wb_off == chd_pkg::ADR_CFG)) begin
         s_nxt.cfg_res = WB_DAT_I[chd_pkg::CFG_RES_LSB +: chd_pkg::CODE_W];
         s_nxt.cfg_prm = WB_DAT_I[chd_pkg::CFG_PRM_LSB +: chd_pkg::CODE_W];
      end

      // Input channel confirmation mirrors the controller's request
      s_nxt.in_conf = 8'h00;
      if (in_en) begin
         s_nxt.in_conf[chd_pkg::ACT_BIT]  = 1'b1;
         s_nxt.in_conf[chd_pkg::MODE_BIT] = IN_SYNC_CONTROL[chd_pkg::MODE_BIT];
      end
      // Source had to stall because the queue was full; cleared by disabling
      // No result is lost: the source simply waits on RES_READY
      s_nxt.ovf = in_en && (s_r.ovf || (in_ack_mode && RES_VALID && !fifo_ready));
      s_nxt.in_conf[chd_pkg::OVF_BIT] = s_nxt.ovf;

      // Publish the next queued result
      s_nxt.res_new = 1'b0;
      if (publish) begin
         s_nxt.res_new = 1'b1;
         s_nxt.serial  = s_r.serial + 1'b1;
         s_nxt.pass    = buf_data[BW-1];
         s_nxt.fail    = buf_data[BW-2];
         s_nxt.res_len = res_len_clamp;
         // Disabled channel: data still published, counter left alone
         // The counter is eight bits and wraps to zero on overflow
         if (in_en) begin
            s_nxt.in_cnt = s_r.in_cnt + 8'h01;
         end
      end

      // Output channel confirmation
      s_nxt.out_conf = 8'h00;
      if (out_en) begin
         s_nxt.out_conf[chd_pkg::ACT_BIT]  = 1'b1;
         s_nxt.out_conf[chd_pkg::MODE_BIT] = OUT_SYNC_CONTROL[chd_pkg::MODE_BIT];
      end

      // Output channel: a changed counter announces new data
      case (s_r.prm_st)
         chd_pkg::PRM_IDLE: begin
            if (!out_en) begin
               // Activation alone must not look like a transfer
               s_nxt.out_seen = OUT_TRANSFER_COUNTER;
            end else if (prm_new) begin
               s_nxt.prm_cnt   = OUT_TRANSFER_COUNTER;
               s_nxt.prm_len   = prm_len_clamp;
               s_nxt.prm_valid = 1'b1;
               s_nxt.prm_st    = chd_pkg::PRM_PEND;
            end
         end
         chd_pkg::PRM_PEND: begin
            // The echo is given only once the consumer has taken the data
            if (PRM_READY) begin
               s_nxt.prm_valid = 1'b0;
               s_nxt.out_seen  = s_r.prm_cnt;
               s_nxt.out_ack   = s_r.prm_cnt;
               s_nxt.prm_st    = chd_pkg::PRM_IDLE;
            end
         end
         default: begin
            s_nxt.prm_st = chd_pkg::PRM_IDLE;
         end
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge MCLK or negedge RESETN) begin
      // Size codes start at the sixteen-byte default; all else clears
      if (!RESETN) begin
         s_r         <= '0;
         s_r.cfg_res <= chd_pkg::RES_CODE_RST;
         s_r.cfg_prm <= chd_pkg::PRM_CODE_RST;
         s_r.prm_st  <= chd_pkg::PRM_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Every output is a state flop; RES_READY is the queue's registered
   // not-full flag, so no path runs combinationally to a pin
   assign WB_DAT_O                = s_r.wb_dat;
   assign WB_ACK_O                = s_r.wb_ack;
   assign RES_READY               = fifo_ready;
   assign RES_NEW                 = s_r.res_new;
   assign RESULT_SERIAL           = s_r.serial;
   assign RES_PASS_OUT            = s_r.pass;
   assign RES_FAIL_OUT            = s_r.fail;
   assign RES_LEN_OUT             = s_r.res_len;
   assign IN_SYNC_CONFIRM_BYTE    = s_r.in_conf;
   assign IN_TRANSFER_COUNTER     = s_r.in_cnt;
   assign OUT_SYNC_CONFIRM_BYTE   = s_r.out_conf;
   assign OUT_ACKNOWLEDGE_COUNTER = s_r.out_ack;
   assign PRM_VALID               = s_r.prm_valid;
   assign PRM_LEN_OUT             = s_r.prm_len;
endmodule
`default_nettype wire

//--- tb/chd_asserts.sv
// Checker for the cyclic data handshake top; sees top ports only.
// Assumes one clock domain, MCLK, and async active-low RESETN.
`timescale 1ns/10ps
`default_nettype none
module chd_asserts (
   // Clock and reset
   input wire logic        MCLK,
   input wire logic        RESETN,
   // Channel bytes
   input wire logic [7:0]  IN_SYNC_CONTROL,
   input wire logic [7:0]  IN_SYNC_CONFIRM_BYTE,
   input wire logic [7:0]  OUT_SYNC_CONTROL,
   input wire logic [7:0]  OUT_SYNC_CONFIRM_BYTE,
   input wire logic [7:0]  IN_TRANSFER_COUNTER,
   input wire logic [7:0]  IN_ACKNOWLEDGE_COUNTER,
   // Result and parameter paths
   input wire logic        RES_NEW,
   input wire logic [23:0] RESULT_SERIAL,
   input wire logic [15:0] RES_LEN_OUT,
   input wire logic        PRM_VALID,
   input wire logic        PRM_READY,
   input wire logic [15:0] PRM_LEN_OUT
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   a_in_confirm: assert property (IN_SYNC_CONFIRM_BYTE[1:0] ==
      ($past(IN_SYNC_CONTROL[0]) ? $past(IN_SYNC_CONTROL[1:0]) : 2'h0)) else $error("input confirm wrong");
   a_out_confirm: assert property (OUT_SYNC_CONFIRM_BYTE[1:0] ==
      ($past(OUT_SYNC_CONTROL[0]) ? $past(OUT_SYNC_CONTROL[1:0]) : 2'h0)) else $error("output confirm wrong");
   a_cnt_step: assert property ((IN_TRANSFER_COUNTER != $past(IN_TRANSFER_COUNTER)) |->
      (RES_NEW && IN_TRANSFER_COUNTER == $past(IN_TRANSFER_COUNTER) + 8'h01)) else $error("counter step wrong");
   a_serial_step: assert property (RESULT_SERIAL == $past(RESULT_SERIAL) + {23'h0, RES_NEW})
      else $error("serial step wrong");
   a_len_bound: assert property (RES_NEW |-> RES_LEN_OUT <= 16'h00F0)
      else $error("result length too big");
   a_ack_wait: assert property ((RES_NEW && $past(IN_SYNC_CONFIRM_BYTE[1:0]) == 2'h3) |->
      $past(IN_ACKNOWLEDGE_COUNTER) == $past(IN_TRANSFER_COUNTER)) else $error("published before ack");
   a_prm_hold: assert property (PRM_VALID && !PRM_READY |=> PRM_VALID && $stable(PRM_LEN_OUT))
      else $error("parameter dropped");
   a_prm_take: assert property (PRM_VALID && PRM_READY |=> !PRM_VALID)
      else $error("parameter not released");
endmodule
bind chd_top chd_asserts chd_asserts_inst (.*);
`default_nettype wire

//--- tb/chd_plc_model.sv
// Controller model: output counter, parameter length, input acknowledge.
// Assumes the bench commands each new output transfer with bump.
`timescale 1ns/10ps
`default_nettype none
module chd_plc_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Bench commands
   input  wire logic        bump,
   input  wire logic [15:0] len_i,
   input  wire logic [3:0]  dly,
   input  wire logic [7:0]  in_ctl,
   // Device image
   input  wire logic [7:0]  dev_cnt,
   // Controller image
   output logic      [7:0]  ack_o,
   output logic      [7:0]  cnt_o,
   output logic      [15:0] len_o
);
   logic [3:0] wt;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_o <= 8'h00;
         cnt_o <= 8'h00;
         len_o <= 16'h0000;
         wt <= 4'h0;
      end else begin
         if (bump) begin
            cnt_o <= cnt_o + 8'h01;
            len_o <= len_i;
         end
         // Simple mode: ack is junk that changes every cycle
         if (in_ctl[1:0] != 2'h3) ack_o <= ~ack_o;
         else if (ack_o == dev_cnt) wt <= 4'h0;
         else if (wt == dly) ack_o <= dev_cnt;
         else wt <= wt + 4'h1;
      end
   end
endmodule
`default_nettype wire

//--- tb/chd_top_tb.sv
// Self-checking bench for chd_top with the controller model.
// Assumes 100 MHz MCLK; expectations queued, a monitor compares.
`timescale 1ns/10ps
`default_nettype none
module chd_top_tb;
   logic MCLK, RESETN, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, RES_VALID, RES_READY, RES_PASS, RES_FAIL;
   logic RES_NEW, RES_PASS_OUT, RES_FAIL_OUT, PRM_VALID, PRM_READY, bump, full;
   logic [3:0] WB_ADR_I, WB_SEL_I, dly;
   logic [31:0] WB_DAT_I, WB_DAT_O, rd;
   logic [15:0] RES_LEN, RES_LEN_OUT, PRM_LEN, PRM_LEN_OUT, plen, l;
   logic [23:0] RESULT_SERIAL, ser;
   logic [7:0] IN_SYNC_CONTROL, IN_ACKNOWLEDGE_COUNTER, IN_SYNC_CONFIRM_BYTE, IN_TRANSFER_COUNTER, ic, oc;
   logic [7:0] OUT_SYNC_CONTROL, OUT_TRANSFER_COUNTER, OUT_SYNC_CONFIRM_BYTE, OUT_ACKNOWLEDGE_COUNTER;
   logic [41:0] rq[$];
   logic [15:0] pq[$];
   logic [15:0] sz[6] = '{16'h0008, 16'h0010, 16'h0020, 16'h0040, 16'h0080, 16'h00F0};
   int fail_count = 0;
   int n_checks = 0;
   int i;

   chd_top chd_top_inst (.*);
   chd_plc_model chd_plc_model_inst (.clk(MCLK), .rst_n(RESETN), .bump(bump), .len_i(plen), .dly(dly),
      .in_ctl(IN_SYNC_CONTROL), .dev_cnt(IN_TRANSFER_COUNTER), .ack_o(IN_ACKNOWLEDGE_COUNTER),
      .cnt_o(OUT_TRANSFER_COUNTER), .len_o(PRM_LEN));

   initial begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task chk(input logic [63:0] e, input logic [63:0] a);
      n_checks++;
      if (a !== e) begin
         fail_count++;
         $display("[ERR] %0t exp %h got %h", $time, e, a);
      end
   endtask
   function logic [15:0] clamp(input logic [15:0] v, input logic [15:0] s);
      return (v > s) ? s : v;
   endfunction
   task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_ADR_I <= a;
      WB_SEL_I <= 4'hF;
      WB_DAT_I <= d;
      @(posedge MCLK);
      while (WB_ACK_O !== 1'b1) @(posedge MCLK);
      rd = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
      @(posedge MCLK);
   endtask
   // Leaves RES_VALID high so results can go back to back
   task send_res(input logic p, input logic [15:0] v, input logic [15:0] e);
      int t;
      t = 0;
      RES_VALID <= 1'b1;
      RES_PASS <= p;
      RES_FAIL <= !p;
      RES_LEN <= v;
      @(posedge MCLK);
      while (RES_READY !== 1'b1 && t < 300) begin
         @(posedge MCLK);
         t++;
      end
      if (t >= 300) fail_count++;
      ser = ser + 24'h000001;
      rq.push_back({ser, p, !p, e});
      if (IN_SYNC_CONTROL[0]) ic++;
   endtask
   task prm(input logic [15:0] v, input logic [15:0] e);
      bump <= 1'b1;
      plen <= v;
      pq.push_back(e);
      oc++;
      @(posedge MCLK);
      bump <= 1'b0;
   endtask
   task drain;
      int t;
      t = 0;
      while ((rq.size() != 0 || pq.size() != 0) && t < 400) begin
         @(posedge MCLK);
         t++;
      end
      if (t >= 400) fail_count++;
      repeat (2) @(posedge MCLK);
   endtask
   task summarize;
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ****************************************
   // Monitor
   // ****************************************
   always @(posedge MCLK) begin
      if (RES_VALID === 1'b1 && RES_READY === 1'b0) full = 1'b1;
      if (RESETN === 1'b1 && RES_NEW === 1'b1) begin
         if (rq.size() == 0) chk(0, 1);
         else chk(rq.pop_front(), {RESULT_SERIAL, RES_PASS_OUT, RES_FAIL_OUT, RES_LEN_OUT});
      end
      if (PRM_VALID === 1'b1 && PRM_READY === 1'b1) begin
         if (pq.size() == 0) chk(0, 1);
         else chk(pq.pop_front(), PRM_LEN_OUT);
      end
   end

   initial begin
      #100000;
      fail_count++;
      summarize();
   end

   initial begin
      {RESETN, WB_CYC_I, WB_STB_I, WB_WE_I, RES_VALID, RES_PASS, RES_FAIL, PRM_READY, bump, full} = '0;
      {WB_ADR_I, WB_DAT_I, RES_LEN, plen, ser, ic, oc, IN_SYNC_CONTROL, OUT_SYNC_CONTROL} = '0;
      WB_SEL_I = 4'hF;
      dly = 4'h6;
      void'($urandom(32'h963E));
      repeat (20) @(posedge MCLK);
      RESETN <= 1'b1;
      @(posedge MCLK);
      wb(1'b0, 4'h0, 32'h0);
      chk(32'h00000011, rd);
      wb(1'b0, 4'hC, 32'h0);
      chk(32'h0, rd);
      IN_SYNC_CONTROL <= 8'h01;
      OUT_SYNC_CONTROL <= 8'h01;
      repeat (3) @(posedge MCLK);
      wb(1'b0, 4'h8, 32'h0);
      chk(32'h00010001, rd);
      for (i = 0; i < 6; i++) begin
         l = 16'($urandom_range(0, 40));
         send_res(1'($urandom_range(0, 1)), l, clamp(l, 16'h0010));
      end
      RES_VALID <= 1'b0;
      prm(16'h0004, 16'h0004);
      repeat (5) @(posedge MCLK);
      chk(1, PRM_VALID);
      PRM_READY <= 1'b1;
      drain();
      chk({ic, oc}, {IN_TRANSFER_COUNTER, OUT_ACKNOWLEDGE_COUNTER});
      for (i = 0; i < 6; i++) begin
         wb(1'b1, 4'h0, 32'((i << 4) | i));
         send_res(1'b1, 16'h00FF, sz[i]);
         RES_VALID <= 1'b0;
         prm(16'h00FF, sz[i]);
         drain();
      end
      wb(1'b1, 4'h0, 32'h00000011);
      IN_SYNC_CONTROL <= 8'h03;
      OUT_SYNC_CONTROL <= 8'h03;
      repeat (3) @(posedge MCLK);
      chk(16'h0303, {IN_SYNC_CONFIRM_BYTE, OUT_SYNC_CONFIRM_BYTE});
      for (i = 0; i < 5; i++) send_res(1'b0, 16'h0003, 16'h0003);
      RES_VALID <= 1'b0;
      prm(16'h0005, 16'h0005);
      drain();
      chk({1'b1, ic, oc}, {full, IN_TRANSFER_COUNTER, OUT_ACKNOWLEDGE_COUNTER});
      chk(1, IN_SYNC_CONFIRM_BYTE[6]);
      IN_SYNC_CONTROL <= 8'h00;
      repeat (3) @(posedge MCLK);
      chk(8'h00, IN_SYNC_CONFIRM_BYTE);
      send_res(1'b1, 16'h0002, 16'h0002);
      RES_VALID <= 1'b0;
      drain();
      chk(ic, IN_TRANSFER_COUNTER);
      summarize();
   end
endmodule
`default_nettype wire
